// *** lsc_map.svh ***
// register offsets, field positions, reset values and timing counts of the converter drive
`ifndef LSC_MAP_SVH
`define LSC_MAP_SVH
`define LSC_REG_CTRL 8'h00
`define LSC_REG_STATUS 8'h04
`define LSC_REG_IRQ_STAT 8'h08
`define LSC_REG_IRQ_MASK 8'h0C
`define LSC_REG_CMD 8'h10
`define LSC_CTRL_POL 0
`define LSC_CTRL_PHASE 1
`define LSC_CTRL_EDGE 2
`define LSC_CTRL_PARAB 3
`define LSC_CTRL_RUN 4
`define LSC_CTRL_RESET 5'h10
`define LSC_ST_EXT 0
`define LSC_ST_ALARM 1
`define LSC_ST_HON 2
`define LSC_ST_BON 3
`define LSC_ST_LATCH 4
`define LSC_IRQ_TRIP 0
`define LSC_IRQ_CLIM 1
`define LSC_IRQ_SEQ 2
`define LSC_IRQ_RESET 3'h0
`define LSC_CMD_CLR 0
`define LSC_CLK_NS 10
`define LSC_TRIG_DELAY_NS 500
`define LSC_ONESHOT_NS 100
`define LSC_SOFT_GAP_NS 20000
`define LSC_OVERVOLTAGE_SENSE_LINES 2
`define LSC_TRIG_DELAY_CYC ((`LSC_TRIG_DELAY_NS + `LSC_CLK_NS - 1) / `LSC_CLK_NS)
`define LSC_ONESHOT_CYC ((`LSC_ONESHOT_NS + `LSC_CLK_NS - 1) / `LSC_CLK_NS)
`define LSC_SOFT_GAP_CYC ((`LSC_SOFT_GAP_NS + `LSC_CLK_NS - 1) / `LSC_CLK_NS)
`endif

// *** lsc_pkg.sv ***
// types shared by the converter drive files
package lsc_pkg;
	typedef enum logic [1:0] {SEQ_OFF, SEQ_H_UP, SEQ_BOTH, SEQ_B_DOWN} lsc_seq_e;
	typedef logic [31:0] lsc_word_t;
endpackage

// *** lsc_sync.sv ***
// three-stage input synchroniser with agreement filter
module lsc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// asynchronous inputs and filtered result
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	// first stage feeds only the second
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	// a change counts only once stages two and three agree
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dout <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_reg[i] == s3_reg[i]) begin
					dout[i] <= s3_reg[i];
				end
			end
		end
	end
endmodule

// *** lsc_drive.sv ***
// line-synchronised converter drive with protection, soft sequencing and avalon registers
`include "lsc_map.svh"
module lsc_drive #(
	parameter int TRIG_CYC = `LSC_TRIG_DELAY_CYC,
	parameter int ONESHOT_CYC = `LSC_ONESHOT_CYC,
	parameter int GAP_CYC = `LSC_SOFT_GAP_CYC,
	parameter int LINES = `LSC_OVERVOLTAGE_SENSE_LINES,
	parameter int CW = 12
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// avalon-mm slave
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// comparator inputs
	input wire logic cfg_cmp,
	input wire logic curr_cmp,
	input wire logic err_cmp,
	input wire logic overvoltage_sense,
	// horizontal timing inputs
	input wire logic hdrive_src,
	input wire logic flyback,
	input wire logic ramp_discharge,
	// drive outputs, converter drive is open collector
	output logic hdrive_out,
	output logic converter_drive_out,
	output logic converter_drive_oe,
	// interrupt
	output logic irq
);
	logic [6:0] sync_q;
	logic cfg_s, curr_s, err_s, ovp_s, hd_s, fly_s, ramp_s, hd_d, fly_d, ramp_d;
	logic [4:0] ctrl_reg;
	logic [2:0] irq_stat_reg, irq_mask_reg;
	logic [CW-1:0] fly_cnt_reg, fly_len_reg, trig_cnt_reg, shot_cnt_reg, gap_cnt_reg;
	logic [1:0] line_cnt_reg;
	logic trig_run_reg, shot_reg, latch_reg, gate_reg, trip_reg, ext_mode_reg;
	logic fly_rise, fly_mid, parab_start, set_event, shot_end, reset_cond, ramp_rise;
	logic req_take, wr_take, clr_wr, trip_set, clim_evt, seq_evt, want_run, hon, bon;
	lsc_pkg::lsc_seq_e seq_reg;
	//////////////////////////////////////////////////////////////////////
	// input conditioning: everything here is off-clock
	lsc_sync #(.W(7)) u_sync (
		.clk(clk),
		.nrst(nrst),
		.din({cfg_cmp, curr_cmp, err_cmp, overvoltage_sense, hdrive_src, flyback, ramp_discharge}),
		.dout(sync_q)
	);
	assign {cfg_s, curr_s, err_s, ovp_s, hd_s, fly_s, ramp_s} = sync_q;
	// previous values for edge detection
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hd_d <= 1'b0;
			fly_d <= 1'b0;
			ramp_d <= 1'b0;
		end else begin
			hd_d <= hd_s;
			fly_d <= fly_s;
			ramp_d <= ramp_s;
		end
	end
	// configuration comparator picks the ramp source
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ext_mode_reg <= 1'b1;
		end else begin
			ext_mode_reg <= !cfg_s;
		end
	end
	//////////////////////////////////////////////////////////////////////
	// flyback length measure; mid point uses last line's length
	assign fly_rise = fly_s && !fly_d;
	assign fly_mid = fly_s && (fly_len_reg != '0) && (fly_cnt_reg == (fly_len_reg >> 1));
	assign parab_start = ctrl_reg[`LSC_CTRL_PARAB] ? fly_mid : fly_rise;
	assign ramp_rise = ramp_s && !ramp_d;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fly_cnt_reg <= '0;
			fly_len_reg <= '0;
		end else if (fly_rise) begin
			fly_cnt_reg <= '0;
		end else if (fly_s) begin
			if (fly_cnt_reg != '1) begin
				fly_cnt_reg <= fly_cnt_reg + 1'b1;
			end
		end else if (fly_d) begin
			fly_len_reg <= fly_cnt_reg; // saturates on very long flybacks
		end
	end
	// trigger delay after mid-flyback
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			trig_run_reg <= 1'b0;
			trig_cnt_reg <= '0;
		end else if (fly_mid && ext_mode_reg && !ctrl_reg[`LSC_CTRL_PHASE]) begin
			trig_run_reg <= 1'b1;
			trig_cnt_reg <= '0;
		end else if (trig_run_reg) begin
			trig_cnt_reg <= trig_cnt_reg + 1'b1;
			if (trig_cnt_reg == CW'(TRIG_CYC - 1)) begin
				trig_run_reg <= 1'b0;
			end
		end
	end
	// set event source; edge bit matters only with phase 1
	always_comb begin
		set_event = 1'b0;
		if (ext_mode_reg) begin
			if (!ctrl_reg[`LSC_CTRL_PHASE]) begin
				set_event = trig_run_reg && (trig_cnt_reg == CW'(TRIG_CYC - 1));
			end else if (ctrl_reg[`LSC_CTRL_EDGE]) begin
				set_event = hd_s && !hd_d;
			end else begin
				set_event = !hd_s && hd_d;
			end
		end
	end
	// one-shot; the drive turns on when it ends
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			shot_reg <= 1'b0;
			shot_cnt_reg <= '0;
		end else if (set_event) begin
			shot_reg <= 1'b1;
			shot_cnt_reg <= '0;
		end else if (shot_reg) begin
			shot_cnt_reg <= shot_cnt_reg + 1'b1;
			if (shot_cnt_reg == CW'(ONESHOT_CYC - 1)) begin
				shot_reg <= 1'b0;
			end
		end
	end
	assign shot_end = shot_reg && (shot_cnt_reg == CW'(ONESHOT_CYC - 1)) && !set_event;
	// current limit only counts with the external ramp
	assign reset_cond = err_s || (ext_mode_reg && curr_s);
	//////////////////////////////////////////////////////////////////////
	// drive latch; reset dominates a coincident set
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			latch_reg <= 1'b0;
		end else if (reset_cond) begin
			latch_reg <= 1'b0;
		end else if (ext_mode_reg ? shot_end : ramp_rise) begin
			latch_reg <= 1'b1;
		end
	end
	// internal ramp: latch reaches the output only from parabola start (flyback start, or mid-flyback with the parab bit)
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gate_reg <= 1'b0;
		end else if (ext_mode_reg || !latch_reg || reset_cond) begin
			gate_reg <= ext_mode_reg;
		end else if (parab_start) begin
			gate_reg <= 1'b1;
		end
	end
	//////////////////////////////////////////////////////////////////////
	// overvoltage: two flyback lines of persistence before trip
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			line_cnt_reg <= '0;
		end else if (!ovp_s || trip_reg) begin
			line_cnt_reg <= '0;
		end else if (fly_rise) begin
			line_cnt_reg <= line_cnt_reg + 1'b1;
		end
	end
	assign trip_set = ovp_s && fly_rise && (line_cnt_reg == 2'(LINES - 1)) && !trip_reg;
	// trip latch; a new trip beats a clear
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			trip_reg <= 1'b0;
		end else if (trip_set) begin
			trip_reg <= 1'b1;
		end else if (clr_wr) begin
			trip_reg <= 1'b0;
		end
	end
	//////////////////////////////////////////////////////////////////////
	// soft start/stop: hdrive leads in and trails out
	assign want_run = ctrl_reg[`LSC_CTRL_RUN] && !trip_reg;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			seq_reg <= lsc_pkg::SEQ_OFF;
			gap_cnt_reg <= '0;
		end else begin
			case (seq_reg)
				lsc_pkg::SEQ_OFF: begin
					gap_cnt_reg <= '0;
					if (want_run) begin
						seq_reg <= lsc_pkg::SEQ_H_UP;
					end
				end
				lsc_pkg::SEQ_H_UP: begin
					gap_cnt_reg <= gap_cnt_reg + 1'b1;
					if (!want_run) begin
						seq_reg <= lsc_pkg::SEQ_B_DOWN;
						gap_cnt_reg <= '0;
					end else if (gap_cnt_reg == CW'(GAP_CYC - 1)) begin
						seq_reg <= lsc_pkg::SEQ_BOTH;
					end
				end
				lsc_pkg::SEQ_BOTH: begin
					gap_cnt_reg <= '0;
					if (!want_run) begin
						seq_reg <= lsc_pkg::SEQ_B_DOWN;
					end
				end
				lsc_pkg::SEQ_B_DOWN: begin
					gap_cnt_reg <= gap_cnt_reg + 1'b1;
					if (gap_cnt_reg == CW'(GAP_CYC - 1)) begin
						seq_reg <= lsc_pkg::SEQ_OFF;
					end
				end
				default: begin
					seq_reg <= lsc_pkg::SEQ_OFF;
				end
			endcase
		end
	end
	assign hon = seq_reg != lsc_pkg::SEQ_OFF;
	assign bon = seq_reg == lsc_pkg::SEQ_BOTH;
	// output stage, all registered
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hdrive_out <= 1'b0;
			converter_drive_out <= 1'b0;
			converter_drive_oe <= 1'b1;
		end else begin
			hdrive_out <= hon && hd_s;
			converter_drive_out <= (bon && latch_reg && gate_reg) ^ ctrl_reg[`LSC_CTRL_POL];
			converter_drive_oe <= !((bon && latch_reg && gate_reg) ^ ctrl_reg[`LSC_CTRL_POL]);
		end
	end
	//////////////////////////////////////////////////////////////////////
	// avalon slave: one wait cycle, then answer
	assign req_take = (read || write) && waitrequest;
	assign wr_take = write && !waitrequest && byteenable[0];
	assign clr_wr = wr_take && (address == `LSC_REG_CMD) && writedata[`LSC_CMD_CLR];
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			waitrequest <= 1'b1;
			readdata <= '0;
		end else begin
			waitrequest <= !req_take;
			if (req_take && read) begin
				case (address)
					`LSC_REG_CTRL: readdata <= {27'h0000000, ctrl_reg};
					`LSC_REG_STATUS: readdata <= {27'h0000000, latch_reg, bon, hon, trip_reg, ext_mode_reg};
					`LSC_REG_IRQ_STAT: readdata <= {29'h00000000, irq_stat_reg};
					`LSC_REG_IRQ_MASK: readdata <= {29'h00000000, irq_mask_reg};
					default: readdata <= '0;
				endcase
			end
		end
	end
	// control and mask registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg <= `LSC_CTRL_RESET;
			irq_mask_reg <= `LSC_IRQ_RESET;
		end else if (wr_take && address == `LSC_REG_CTRL) begin
			ctrl_reg <= writedata[4:0];
		end else if (wr_take && address == `LSC_REG_IRQ_MASK) begin
			irq_mask_reg <= writedata[2:0];
		end
	end
	// sticky events, write one to clear, set wins
	assign clim_evt = ext_mode_reg && curr_s && latch_reg;
	assign seq_evt = (seq_reg == lsc_pkg::SEQ_H_UP || seq_reg == lsc_pkg::SEQ_B_DOWN)
		&& (gap_cnt_reg == CW'(GAP_CYC - 1));
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_stat_reg <= `LSC_IRQ_RESET;
			irq <= 1'b0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~((wr_take && address == `LSC_REG_IRQ_STAT) ?
				writedata[2:0] : 3'h0)) | {seq_evt, clim_evt, trip_set};
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end
	//////////////////////////////////////////////////////////////////////
	// checks
	property p_ext_sel;
		@(posedge clk) disable iff (!nrst) 1'b1 |=> ext_mode_reg == !$past(cfg_s);
	endproperty
	a_ext_sel: assert property (p_ext_sel) else $error("ramp mode not tracking comparator");
	property p_rise_edge;
		@(posedge clk) disable iff (!nrst)
		ext_mode_reg && ctrl_reg[1] && ctrl_reg[2] && hd_s && !hd_d |=> shot_reg;
	endproperty
	a_rise_edge: assert property (p_rise_edge) else $error("rising edge did not fire");
	property p_fall_edge;
		@(posedge clk) disable iff (!nrst)
		ext_mode_reg && ctrl_reg[1] && !ctrl_reg[2] && hd_s && !hd_d && !set_event |=> !$rose(shot_reg);
	endproperty
	a_fall_edge: assert property (p_fall_edge) else $error("rising edge fired in falling mode");
	property p_shot_set;
		@(posedge clk) disable iff (!nrst)
		ext_mode_reg && $fell(shot_reg) && !$past(set_event) && !reset_cond && !$past(reset_cond)
		|-> latch_reg;
	endproperty
	a_shot_set: assert property (p_shot_set) else $error("latch not set after one-shot");
	property p_curr_rst;
		@(posedge clk) disable iff (!nrst) ext_mode_reg && curr_s |=> !latch_reg;
	endproperty
	a_curr_rst: assert property (p_curr_rst) else $error("current limit did not reset");
	property p_err_rst;
		@(posedge clk) disable iff (!nrst) err_s |=> !latch_reg;
	endproperty
	a_err_rst: assert property (p_err_rst) else $error("error comparator did not reset");
	property p_int_hold;
		@(posedge clk) disable iff (!nrst)
		!ext_mode_reg && latch_reg && !err_s ##1 !ext_mode_reg |-> latch_reg;
	endproperty
	a_int_hold: assert property (p_int_hold) else $error("internal latch reset without error");
	property p_pol;
		@(posedge clk) disable iff (!nrst)
		1'b1 |=> converter_drive_out == ($past(bon && latch_reg && gate_reg) ^ $past(ctrl_reg[0]));
	endproperty
	a_pol: assert property (p_pol) else $error("drive polarity wrong");
	property p_order;
		@(posedge clk) disable iff (!nrst) $rose(bon) |-> $past(hon, 2);
	endproperty
	a_order: assert property (p_order) else $error("converter drive led hdrive");
	property p_trip_off;
		@(posedge clk) disable iff (!nrst) $rose(trip_reg) |-> ##[0:1] !bon;
	endproperty
	a_trip_off: assert property (p_trip_off) else $error("trip left converter drive on");
	property p_trip_cause;
		@(posedge clk) disable iff (!nrst) $rose(trip_reg) |-> $past(ovp_s) && $past(line_cnt_reg) == 2'(LINES - 1);
	endproperty
	a_trip_cause: assert property (p_trip_cause) else $error("trip without two lines");
	property p_latched;
		@(posedge clk) disable iff (!nrst) trip_reg && !clr_wr |=> trip_reg;
	endproperty
	a_latched: assert property (p_latched) else $error("protection released by itself");
	c_trip: cover property (@(posedge clk) disable iff (!nrst) $rose(trip_reg));
	c_b_on: cover property (@(posedge clk) disable iff (!nrst) $rose(bon));
	c_int_gate: cover property (@(posedge clk) disable iff (!nrst) !ext_mode_reg && $rose(gate_reg));
	c_clr: cover property (@(posedge clk) disable iff (!nrst) trip_reg ##1 !trip_reg);
endmodule

// *** lsc_far_side.sv ***
// far-side model: horizontal timing source and feedback comparators
module lsc_far_side #(
	parameter int LINE = 64
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// trip positions within the line, 127 never trips
	input wire logic [6:0] err_at,
	input wire logic [6:0] curr_at,
	// timing and comparator outputs
	output logic hdrive_src,
	output logic flyback,
	output logic ramp_discharge,
	output logic curr_cmp,
	output logic err_cmp,
	output logic [6:0] line_pos
);
	// free-running line counter; timing runs whatever the drive does
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			line_pos <= 7'h00;
		end else begin
			line_pos <= (line_pos == 7'(LINE - 1)) ? 7'h00 : line_pos + 7'h01;
		end
	end
	// flyback opens the line, drive waveform mid-line, discharge closes it
	assign flyback = line_pos < 7'h10;
	assign hdrive_src = line_pos >= 7'h18 && line_pos < 7'h38;
	assign ramp_discharge = line_pos >= 7'h38;
	// pulses six wide so the input filter lets them through
	assign err_cmp = line_pos >= err_at && line_pos < err_at + 7'h06;
	assign curr_cmp = line_pos >= curr_at && line_pos < curr_at + 7'h06;
endmodule

// *** lsc_drive_tb.sv ***
// self-checking bench for the converter drive
`include "lsc_map.svh"
module lsc_drive_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LINE = 64;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] address = 8'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'hF;
	logic [31:0] readdata;
	logic waitrequest, hdrive_out, converter_drive_out, converter_drive_oe, irq;
	logic cfg_cmp = 1'b0;
	logic ov = 1'b0;
	logic curr_cmp, err_cmp, hdrive_src, flyback, ramp_discharge;
	logic [6:0] err_at = 7'h7F;
	logic [6:0] curr_at = 7'h7F;
	logic [6:0] line_pos;
	logic pol = 1'b0;
	logic active;
	logic hd_seen;
	logic [31:0] rd;
	int err_count = 0;
	int tests_run = 0;
	int i;
	// one row per drive configuration
	int cfg_v[6] = '{0, 0, 0, 0, 1, 1};
	logic [4:0] ctrl_v[6] = '{5'h14, 5'h12, 5'h16, 5'h15, 5'h16, 5'h18};
	int on_v[6] = '{13, 58, 26, 13, 0, 8};
	int err_v[6] = '{40, 20, 50, 50, 40, 40};
	int curr_v[6] = '{127, 127, 127, 30, 30, 127};
	int off_v[6] = '{40, 20, 50, 30, 40, 40};
	assign active = converter_drive_out ^ pol;
	always #5 clk = ~clk;
	// short counts keep a line of 64 cycles meaningful
	lsc_drive #(.TRIG_CYC(3), .ONESHOT_CYC(2), .GAP_CYC(8), .LINES(2)) lsc_drive_i (
		.clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .cfg_cmp(cfg_cmp), .curr_cmp(curr_cmp),
		.err_cmp(err_cmp), .overvoltage_sense(ov), .hdrive_src(hdrive_src),
		.flyback(flyback), .ramp_discharge(ramp_discharge), .hdrive_out(hdrive_out),
		.converter_drive_out(converter_drive_out), .converter_drive_oe(converter_drive_oe),
		.irq(irq));
	lsc_far_side #(.LINE(LINE)) lsc_far_side_i (
		.clk(clk), .nrst(nrst), .err_at(err_at), .curr_at(curr_at),
		.hdrive_src(hdrive_src), .flyback(flyback), .ramp_discharge(ramp_discharge),
		.curr_cmp(curr_cmp), .err_cmp(err_cmp), .line_pos(line_pos));
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// one idle edge first so strobes never rise in the step they fell
	task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge clk);
		address <= a;
		writedata <= d;
		byteenable <= be;
		write <= wr;
		read <= !wr;
		// no cycle count assumed; a hung slave is ended by the watchdog
		do begin
			@(posedge clk);
		end while (waitrequest !== 1'b0);
		rd = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask
	task automatic stat_bits(input logic [1:0] exp, input string name);
		bus_xfer(1'b0, `LSC_REG_STATUS, 32'h0, 4'hF);
		check(name, rd[`LSC_ST_BON:`LSC_ST_HON], exp);
	endtask
	task automatic wait_pos(input int p);
		int n;
		for (n = 0; n < 200; n++) begin
			@(posedge clk);
			if (line_pos == 7'(p)) break;
		end
	endtask
	// edge of the drive must land 2..9 cycles after its cause in the line
	task automatic wait_drive(input logic lvl, input int base, input string name);
		int n;
		int d;
		logic prev;
		prev = active;
		d = -1;
		for (n = 0; n < 300; n++) begin
			@(posedge clk);
			if (active === lvl && prev !== lvl) begin
				d = (int'(line_pos) - base + 128) % LINE;
				break;
			end
			prev = active;
		end
		check(name, 32'(d >= 2 && d <= 9), 32'h1);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#300000;
		err_count++;
		give_verdict();
	end
	initial begin
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		repeat (30) @(posedge clk);
		// reset value, byte-enable refusal, unmapped read
		bus_xfer(1'b0, `LSC_REG_CTRL, 32'h0, 4'hF);
		check("ctrl reset", rd, 32'h10);
		bus_xfer(1'b1, `LSC_REG_CTRL, 32'h0, 4'h0);
		bus_xfer(1'b0, `LSC_REG_CTRL, 32'h0, 4'hF);
		check("ctrl masked write", rd, 32'h10);
		bus_xfer(1'b0, 8'h20, 32'h0, 4'hF);
		check("unmapped", rd, 32'h0);
		// phase-out then phase-in by bus command
		bus_xfer(1'b1, `LSC_REG_CTRL, 32'h0, 4'hF);
		stat_bits(2'b01, "stop order");
		repeat (30) @(posedge clk);
		stat_bits(2'b00, "stopped");
		bus_xfer(1'b1, `LSC_REG_CTRL, 32'h10, 4'hF);
		stat_bits(2'b01, "start order");
		repeat (30) @(posedge clk);
		stat_bits(2'b11, "started");
		// horizontal drive follows its source once phased in
		wait_pos(40);
		check("hdrive passes", hdrive_out, 1'b1);
		wait_pos(10);
		check("hdrive follows source", hdrive_out, 1'b0);
		// every ramp, phase, edge and polarity choice
		for (i = 0; i < 6; i++) begin
			cfg_cmp <= cfg_v[i][0];
			err_at <= 7'(err_v[i]);
			curr_at <= 7'(curr_v[i]);
			pol = ctrl_v[i][0];
			bus_xfer(1'b1, `LSC_REG_CTRL, 32'(ctrl_v[i]), 4'hF);
			repeat (2 * LINE) @(posedge clk);
			bus_xfer(1'b0, `LSC_REG_STATUS, 32'h0, 4'hF);
			check("ext ramp", rd[`LSC_ST_EXT], !cfg_v[i][0]);
			wait_drive(1'b1, on_v[i], "on time");
			wait_drive(1'b0, off_v[i], "off time");
			check("idle level", converter_drive_out, pol);
			check("idle oe", converter_drive_oe, !pol);
		end
		// short overvoltage of one flyback must be dropped
		cfg_cmp <= 1'b0;
		err_at <= 7'd40;
		curr_at <= 7'h7F;
		pol = 1'b0;
		bus_xfer(1'b1, `LSC_REG_CTRL, 32'h14, 4'hF);
		bus_xfer(1'b1, `LSC_REG_IRQ_MASK, 32'h1, 4'hF);
		bus_xfer(1'b0, `LSC_REG_IRQ_MASK, 32'h0, 4'hF);
		check("mask readback", rd, 32'h1);
		// current limit and sequence steps have left their sticky bits
		bus_xfer(1'b0, `LSC_REG_IRQ_STAT, 32'h0, 4'hF);
		check("event bits", rd, 32'h6);
		bus_xfer(1'b1, `LSC_REG_IRQ_STAT, 32'h7, 4'hF);
		wait_pos(32);
		ov <= 1'b1;
		wait_pos(20);
		ov <= 1'b0;
		bus_xfer(1'b0, `LSC_REG_STATUS, 32'h0, 4'hF);
		check("spike alarm", rd[`LSC_ST_ALARM], 1'b0);
		check("spike irq", irq, 1'b0);
		// held overvoltage: one more line runs, then both drives stop
		wait_pos(32);
		ov <= 1'b1;
		wait_drive(1'b1, 13, "line before trip");
		repeat (LINE) @(posedge clk);
		bus_xfer(1'b0, `LSC_REG_STATUS, 32'h0, 4'hF);
		check("alarm", rd[`LSC_ST_ALARM], 1'b1);
		check("drives off", rd[`LSC_ST_BON:`LSC_ST_HON], 2'b00);
		check("trip irq", irq, 1'b1);
		hd_seen = 1'b0;
		repeat (LINE) begin
			@(posedge clk);
			hd_seen = hd_seen | hdrive_out | active;
		end
		check("outputs held off", hd_seen, 1'b0);
		ov <= 1'b0;
		// mask hides the level, status clear removes it
		bus_xfer(1'b1, `LSC_REG_IRQ_MASK, 32'h0, 4'hF);
		repeat (3) @(posedge clk);
		check("masked irq", irq, 1'b0);
		bus_xfer(1'b1, `LSC_REG_IRQ_MASK, 32'h1, 4'hF);
		repeat (3) @(posedge clk);
		check("unmasked irq", irq, 1'b1);
		bus_xfer(1'b1, `LSC_REG_IRQ_STAT, 32'h1, 4'hF);
		repeat (3) @(posedge clk);
		check("cleared irq", irq, 1'b0);
		// protection stays latched until the clear command
		bus_xfer(1'b0, `LSC_REG_STATUS, 32'h0, 4'hF);
		check("latched alarm", rd[`LSC_ST_ALARM], 1'b1);
		bus_xfer(1'b1, `LSC_REG_CMD, 32'h1, 4'hF);
		bus_xfer(1'b0, `LSC_REG_STATUS, 32'h0, 4'hF);
		check("alarm cleared", rd[`LSC_ST_ALARM], 1'b0);
		repeat (40) @(posedge clk);
		stat_bits(2'b11, "restart");
		give_verdict();
	end
endmodule
